// [hw/eis_pkg.sv]
package eis_pkg;

  localparam int BYTE_BITS = 8;
  localparam logic [3:0] CNT_ZERO = 4'h0;
  localparam logic [3:0] CNT_ONE = 4'h1;
  localparam logic [3:0] ACK_SLOT = 4'h8;
  localparam logic [3:0] ACK_DONE = 4'h9;

  // Select byte layout, sent most significant bit first
  localparam int SEL_TYPE_MSB = 7;
  localparam int SEL_TYPE_LSB = 4;
  localparam int SEL_CE_MSB = 3;
  localparam int SEL_CE_LSB = 1;
  localparam int SEL_RW_BIT = 0;
  localparam logic RW_READ = 1'b1;

  // Array size variants in kbit
  localparam int KBIT_DEFAULT = 2;
  localparam int KBIT_4 = 4;
  localparam int KBIT_8 = 8;
  localparam int KBIT_16 = 16;
  localparam logic [2:0] CE_MASK_ALL = 3'h7;
  localparam logic [2:0] CE_MASK_4K = 3'h6;
  localparam logic [2:0] CE_MASK_8K = 3'h4;
  localparam logic [2:0] CE_MASK_16K = 3'h0;

  // Arbitrary type code, not that of any real part
  localparam logic [3:0] TYPE_ID_DEFAULT = 4'h6;

  typedef struct packed {
    logic scl;
    logic sda;
    logic write_protect_input;
    logic chip_select_pin_high;
    logic chip_select_pin_mid;
    logic chip_select_pin_low;
    logic por_reset_n;
  } eis_pins_type;

  localparam eis_pins_type PINS_RESET = '{
    scl: 1'b1,
    sda: 1'b1,
    write_protect_input: 1'b0,
    chip_select_pin_high: 1'b0,
    chip_select_pin_mid: 1'b0,
    chip_select_pin_low: 1'b0,
    por_reset_n: 1'b0
  };

  typedef struct packed {
    logic array_addr_bit_ten;
    logic array_addr_bit_nine;
    logic array_addr_bit_eight;
  } eis_upper_addr_type;

  typedef struct packed {
    logic read_dir;
    eis_upper_addr_type upper;
    logic [7:0] word_addr;
    logic [7:0] data;
  } eis_xfer_type;

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_SELECT,
    ST_ADDR,
    ST_DATA,
    ST_READ
  } eis_state_type;

  // Chip select bits that still take part in pin matching
  function automatic logic [2:0] eis_ce_mask(input int kbit);
    logic [2:0] mask;
    mask = CE_MASK_ALL;
    if (kbit == KBIT_4) begin
      mask = CE_MASK_4K;
    end else if (kbit == KBIT_8) begin
      mask = CE_MASK_8K;
    end else if (kbit == KBIT_16) begin
      mask = CE_MASK_16K;
    end
    return mask;
  endfunction : eis_ce_mask

endpackage : eis_pkg

// [hw/eis_sync.sv]
`timescale 1ns/1ps
`default_nettype none
module eis_sync #(
  parameter int WIDTH = 1,
  parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
  input wire logic clk,
  input wire logic rstn,
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);

  typedef struct packed {
    logic [WIDTH-1:0] meta;
    logic [WIDTH-1:0] stable;
  } eis_sync_state_type;

  eis_sync_state_type r;
  eis_sync_state_type next_r;

  always_comb begin
    next_r = r;
    next_r.meta = async_in;
    next_r.stable = r.meta;
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      r <= {RESET_VAL, RESET_VAL};
    end else begin
      r <= next_r;
    end
  end

  assign sync_out = r.stable;

endmodule : eis_sync
`default_nettype wire

// [hw/eis_link_sampler.sv]
`timescale 1ns/1ps
`default_nettype none
module eis_link_sampler (
  input wire logic link_clk,
  input wire logic rstn,
  input wire logic sda_in,
  output logic bit_toggle,
  output logic bit_value
);

  typedef struct packed {
    logic toggle;
    logic value;
  } eis_link_state_type;

  eis_link_state_type r;
  eis_link_state_type next_r;

  always_comb begin
    next_r = r;
    next_r.toggle = ~r.toggle;
    next_r.value = sda_in;
  end

  // Serial clock may stand still through reset, so reset acts at once
  always_ff @(posedge link_clk or negedge rstn) begin
    if (!rstn) begin
      r <= '0;
    end else begin
      r <= next_r;
    end
  end

  assign bit_toggle = r.toggle;
  assign bit_value = r.value;

endmodule : eis_link_sampler
`default_nettype wire

// [hw/eis_select_front_end.sv]
// Functional notes
// - Slave only; all transfers clocked by master's serial clock, never initiated.
// - Built-in 4-bit type code; select byte accepted only if field matches.
// - Select byte MSB first: type b7-b4, enable field b3-b1, direction b0.
// - Select bits b3, b2, b1 compared against the three chip select pins.
// - Larger variants use select bits as upper array address, excluded from match.
// - Device drives acknowledge in ninth bit after each byte the master writes.
// - While power-on reset asserted, no operation and no response at all.
// - Data line driven open-drain only: pull low or release.
// - Write protect low allows writes to whole array; high refuses them.
// - Unconnected write protect reads as low, so writes are allowed.
// - With write protect high, select and address acked, data bytes not.
// - Chip select pins may change; current level used at each comparison.
// - START is data falling while clock high.
// - STOP is data rising while clock high.
// - Data bits sampled on rising clock; master changes data while clock low.
// - Unmatched select byte gets no ack; release bus, standby until next START.
`timescale 1ns/1ps
`default_nettype none
module eis_select_front_end #(
  parameter int MEM_KBIT = eis_pkg::KBIT_DEFAULT,
  parameter logic [3:0] TYPE_ID = eis_pkg::TYPE_ID_DEFAULT
) (
  input wire logic clk,
  input wire logic rstn,
  input wire logic scl_clk,
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe_n,
  input wire logic write_protect_input,
  input wire logic chip_select_pin_high,
  input wire logic chip_select_pin_mid,
  input wire logic chip_select_pin_low,
  input wire logic por_reset_n,
  output logic selected,
  output logic select_hit,
  output logic select_miss,
  output eis_pkg::eis_xfer_type xfer,
  output logic data_valid,
  output logic data_refused,
  output logic write_stop,
  output logic read_nack,
  output logic frame_abort
);

  localparam logic [2:0] CE_MASK = eis_pkg::eis_ce_mask(MEM_KBIT);

  typedef struct packed {
    eis_pkg::eis_state_type st;
    eis_pkg::eis_state_type pend;
    logic [3:0] bit_cnt;
    logic [7:0] shift;
    logic drive_low;
    logic prev_scl;
    logic prev_sda;
    logic prev_tog;
    logic wp_seen;
    logic commit_armed;
    logic master_nack;
    logic selected;
    logic select_hit;
    logic select_miss;
    eis_pkg::eis_xfer_type xfer;
    logic data_valid;
    logic data_refused;
    logic write_stop;
    logic read_nack;
    logic frame_abort;
  } eis_fe_state_type;

  localparam eis_fe_state_type FE_RESET = '{
    st: eis_pkg::ST_IDLE,
    pend: eis_pkg::ST_IDLE,
    bit_cnt: eis_pkg::CNT_ZERO,
    shift: 8'h00,
    drive_low: 1'b0,
    prev_scl: 1'b1,
    prev_sda: 1'b1,
    prev_tog: 1'b0,
    wp_seen: 1'b0,
    commit_armed: 1'b0,
    master_nack: 1'b0,
    selected: 1'b0,
    select_hit: 1'b0,
    select_miss: 1'b0,
    xfer: '0,
    data_valid: 1'b0,
    data_refused: 1'b0,
    write_stop: 1'b0,
    read_nack: 1'b0,
    frame_abort: 1'b0
  };

  eis_pkg::eis_pins_type raw_pins;
  eis_pkg::eis_pins_type pins;
  logic link_toggle;
  logic link_bit;
  logic tog_sync;

  eis_fe_state_type r;
  eis_fe_state_type next_r;

  logic start_ev;
  logic stop_ev;
  logic scl_fall;
  logic bit_ev;
  logic type_ok;
  logic ce_ok;
  logic [2:0] ce_pins;
  logic wp_now;

  always_comb begin
    raw_pins = eis_pkg::PINS_RESET;
    raw_pins.scl = scl_in;
    raw_pins.sda = sda_in;
    raw_pins.write_protect_input = write_protect_input;
    raw_pins.chip_select_pin_high = chip_select_pin_high;
    raw_pins.chip_select_pin_mid = chip_select_pin_mid;
    raw_pins.chip_select_pin_low = chip_select_pin_low;
    raw_pins.por_reset_n = por_reset_n;
  end

  eis_sync #(
    .WIDTH($bits(eis_pkg::eis_pins_type)),
    .RESET_VAL(eis_pkg::PINS_RESET)
  ) u_pin_sync (
    .clk(clk),
    .rstn(rstn),
    .async_in(raw_pins),
    .sync_out(pins)
  );

  // Bits are captured on the serial clock and handed over by toggle
  eis_link_sampler u_link (
    .link_clk(scl_clk),
    .rstn(rstn),
    .sda_in(sda_in),
    .bit_toggle(link_toggle),
    .bit_value(link_bit)
  );

  eis_sync #(
    .WIDTH(1),
    .RESET_VAL(1'b0)
  ) u_tog_sync (
    .clk(clk),
    .rstn(rstn),
    .async_in(link_toggle),
    .sync_out(tog_sync)
  );

  always_comb begin
    start_ev = r.prev_scl & pins.scl & r.prev_sda & ~pins.sda;
    stop_ev = r.prev_scl & pins.scl & ~r.prev_sda & pins.sda;
    scl_fall = r.prev_scl & ~pins.scl;
    bit_ev = tog_sync ^ r.prev_tog;
    wp_now = pins.write_protect_input;
    ce_pins = {pins.chip_select_pin_high, pins.chip_select_pin_mid,
               pins.chip_select_pin_low};
    type_ok = r.shift[eis_pkg::SEL_TYPE_MSB:eis_pkg::SEL_TYPE_LSB]
              == TYPE_ID;
    ce_ok = (r.shift[eis_pkg::SEL_CE_MSB:eis_pkg::SEL_CE_LSB] & CE_MASK)
            == (ce_pins & CE_MASK);
  end

  always_comb begin
    next_r = r;
    next_r.prev_scl = pins.scl;
    next_r.prev_sda = pins.sda;
    next_r.prev_tog = tog_sync;
    next_r.select_hit = 1'b0;
    next_r.select_miss = 1'b0;
    next_r.data_valid = 1'b0;
    next_r.data_refused = 1'b0;
    next_r.write_stop = 1'b0;
    next_r.read_nack = 1'b0;
    next_r.frame_abort = 1'b0;

    if (r.st == eis_pkg::ST_SELECT || r.st == eis_pkg::ST_ADDR) begin
      next_r.wp_seen = r.wp_seen | wp_now;
    end

    if (start_ev) begin
      // Repeated start inside a byte abandons it
      // The clock rise just before a start counts as one bit
      next_r.frame_abort = (r.st != eis_pkg::ST_IDLE)
                           && (r.bit_cnt > eis_pkg::CNT_ONE);
      next_r.st = eis_pkg::ST_SELECT;
      next_r.pend = eis_pkg::ST_IDLE;
      next_r.bit_cnt = eis_pkg::CNT_ZERO;
      next_r.shift = 8'h00;
      next_r.drive_low = 1'b0;
      next_r.wp_seen = wp_now;
      next_r.commit_armed = 1'b0;
      next_r.master_nack = 1'b0;
      next_r.selected = 1'b0;
    end else if (stop_ev) begin
      // Only a stop right after an acked data byte commits
      next_r.write_stop = r.commit_armed
                          && (r.st == eis_pkg::ST_DATA)
                          && (r.bit_cnt <= eis_pkg::CNT_ONE);
      next_r.read_nack = r.master_nack && (r.st == eis_pkg::ST_READ);
      next_r.frame_abort = (r.st != eis_pkg::ST_IDLE)
                           && (r.bit_cnt > eis_pkg::CNT_ONE);
      next_r.st = eis_pkg::ST_IDLE;
      next_r.pend = eis_pkg::ST_IDLE;
      next_r.bit_cnt = eis_pkg::CNT_ZERO;
      next_r.shift = 8'h00;
      next_r.drive_low = 1'b0;
      next_r.commit_armed = 1'b0;
      next_r.master_nack = 1'b0;
      next_r.selected = 1'b0;
    end else if (r.st != eis_pkg::ST_IDLE) begin
      if (bit_ev) begin
        if (r.bit_cnt < eis_pkg::ACK_SLOT) begin
          next_r.shift = {r.shift[6:0], link_bit};
          next_r.bit_cnt = r.bit_cnt + eis_pkg::CNT_ONE;
          // A stop's own clock rise must not disarm the commit
          next_r.commit_armed = r.commit_armed
                                && (r.bit_cnt == eis_pkg::CNT_ZERO);
        end else if (r.bit_cnt == eis_pkg::ACK_DONE
                     && r.st == eis_pkg::ST_READ) begin
          next_r.master_nack = link_bit;
        end
      end else if (scl_fall) begin
        if (r.bit_cnt == eis_pkg::ACK_SLOT) begin
          next_r.bit_cnt = eis_pkg::ACK_DONE;
          unique case (r.st)
            eis_pkg::ST_SELECT: begin
              if (type_ok && ce_ok) begin
                next_r.drive_low = 1'b1;
                next_r.selected = 1'b1;
                next_r.select_hit = 1'b1;
                next_r.xfer.read_dir = r.shift[eis_pkg::SEL_RW_BIT];
                next_r.xfer.upper = r.shift[eis_pkg::SEL_CE_MSB:
                                            eis_pkg::SEL_CE_LSB]
                                    & ~CE_MASK;
                if (r.shift[eis_pkg::SEL_RW_BIT] == eis_pkg::RW_READ) begin
                  next_r.pend = eis_pkg::ST_READ;
                end else begin
                  next_r.pend = eis_pkg::ST_ADDR;
                end
              end else begin
                next_r.st = eis_pkg::ST_IDLE;
                next_r.bit_cnt = eis_pkg::CNT_ZERO;
                next_r.shift = 8'h00;
                next_r.drive_low = 1'b0;
                next_r.select_miss = 1'b1;
              end
            end
            eis_pkg::ST_ADDR: begin
              next_r.drive_low = 1'b1;
              next_r.xfer.word_addr = r.shift;
              next_r.pend = eis_pkg::ST_DATA;
            end
            eis_pkg::ST_DATA: begin
              next_r.pend = eis_pkg::ST_DATA;
              if (r.wp_seen || wp_now) begin
                next_r.drive_low = 1'b0;
                next_r.data_refused = 1'b1;
              end else begin
                next_r.drive_low = 1'b1;
                next_r.xfer.data = r.shift;
                next_r.data_valid = 1'b1;
                next_r.commit_armed = 1'b1;
              end
            end
            eis_pkg::ST_READ: begin
              // Byte output is outside this block; line stays released
              next_r.drive_low = 1'b0;
              next_r.pend = eis_pkg::ST_READ;
            end
            eis_pkg::ST_IDLE: begin
              next_r.drive_low = 1'b0;
            end
          endcase
        end else if (r.bit_cnt == eis_pkg::ACK_DONE) begin
          next_r.drive_low = 1'b0;
          next_r.bit_cnt = eis_pkg::CNT_ZERO;
          next_r.shift = 8'h00;
          next_r.st = r.pend;
        end
      end
    end else begin
      next_r.bit_cnt = eis_pkg::CNT_ZERO;
      next_r.shift = 8'h00;
      next_r.drive_low = 1'b0;
    end

    // Lockout holds every path quiet until power is good
    if (!pins.por_reset_n) begin
      next_r = FE_RESET;
      next_r.prev_scl = pins.scl;
      next_r.prev_sda = pins.sda;
      next_r.prev_tog = tog_sync;
    end
  end

  // Runs only on the local clock; serial clock only paces bit capture
  always_ff @(posedge clk) begin
    if (!rstn) begin
      r <= FE_RESET;
    end else begin
      r <= next_r;
    end
  end

  assign sda_out = 1'b0;
  assign sda_oe_n = ~r.drive_low;
  assign selected = r.selected;
  assign select_hit = r.select_hit;
  assign select_miss = r.select_miss;
  assign xfer = r.xfer;
  assign data_valid = r.data_valid;
  assign data_refused = r.data_refused;
  assign write_stop = r.write_stop;
  assign read_nack = r.read_nack;
  assign frame_abort = r.frame_abort;

endmodule : eis_select_front_end
`default_nettype wire

// [tb/eis_bus_master.sv]
`timescale 1ns/1ps
`default_nettype none
module eis_bus_master (
  input wire logic clk,
  input wire logic sda_line,
  output logic scl,
  output logic sda
);
  task automatic gap(input int n);
    repeat (n) @(posedge clk);
    #2;
  endtask : gap
  task automatic start();
    sda = 1'b1;
    gap(6);
    scl = 1'b1;
    gap(12);
    sda = 1'b0;
    gap(12);
    scl = 1'b0;
  endtask : start
  task automatic stop();
    gap(6);
    sda = 1'b0;
    gap(6);
    scl = 1'b1;
    gap(12);
    sda = 1'b1;
    gap(12);
  endtask : stop
  task automatic pulse(input logic b, output logic v);
    gap(6);
    sda = b;
    gap(6);
    scl = 1'b1;
    gap(12);
    v = sda_line;
    scl = 1'b0;
  endtask : pulse
  // Eight bits MSB first, then the ninth slot, pulled low when mack
  task automatic xfer(input logic [7:0] b, input logic mack,
                      output logic ack);
    logic v;
    for (int i = 7; i >= 0; i--) begin
      pulse(b[i], v);
    end
    pulse(~mack, v);
    ack = ~v;
  endtask : xfer
  initial begin
    scl = 1'b1;
    sda = 1'b1;
  end
endmodule : eis_bus_master
`default_nettype wire

// [tb/eis_select_properties.sv]
`timescale 1ns/1ps
`default_nettype none
module eis_select_properties (
  input wire logic clk,
  input wire logic rstn,
  input wire logic scl_in,
  input wire logic sda_out,
  input wire logic sda_oe_n,
  input wire logic por_reset_n,
  input wire logic selected,
  input wire logic select_hit,
  input wire logic select_miss,
  input wire logic data_valid,
  input wire logic data_refused
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rstn);
  sequence por_held;
    !por_reset_n [*6];
  endsequence
  sequence ack_hold;
    !sda_oe_n [*8];
  endsequence
  open_drain_a: assert property (sda_out == 1'b0)
    else $error("data output not tied low");
  reset_idle_a: assert property ($rose(rstn) |-> sda_oe_n && !selected)
    else $error("not idle after reset");
  por_lockout_a: assert property (por_held |-> sda_oe_n && !selected
    && !select_hit && !data_valid) else $error("active in lockout");
  ack_length_a: assert property ($fell(sda_oe_n) |-> ack_hold)
    else $error("ack too short");
  ack_release_a: assert property ($fell(sda_oe_n) |-> ##[1:300] sda_oe_n)
    else $error("ack never released");
  ack_scl_low_a: assert property ($fell(sda_oe_n) || $rose(sda_oe_n)
    |-> !scl_in) else $error("data changed with clock high");
  hit_ack_a: assert property (select_hit |-> ##[0:1] !sda_oe_n && selected)
    else $error("select hit without ack");
  miss_release_a: assert property (select_miss
    |-> (sda_oe_n && !selected) [*8]) else $error("miss not released");
  refuse_nack_a: assert property (data_refused
    |-> (sda_oe_n && !data_valid) [*8]) else $error("refused byte acked");
  accept_ack_a: assert property (data_valid |-> ##[0:1] !sda_oe_n)
    else $error("data valid without ack");
endmodule : eis_select_properties
bind eis_select_front_end eis_select_properties i_props (
  .clk(clk), .rstn(rstn), .scl_in(scl_in), .sda_out(sda_out),
  .sda_oe_n(sda_oe_n), .por_reset_n(por_reset_n), .selected(selected),
  .select_hit(select_hit), .select_miss(select_miss),
  .data_valid(data_valid), .data_refused(data_refused));
`default_nettype wire

// [tb/eis_select_front_end_tb_top.sv]
`timescale 1ns/1ps
`default_nettype none
module eis_select_front_end_tb_top;
  logic clk, rstn, scl, m_sda, wp, cs_hi, cs_mid, cs_lo, por_n;
  logic oe_n, oe_n_w, sda_out, sda_out_w, sda_line;
  logic selected, hit, miss, dv, dref, wstop, rnack, fab, sel_w;
  eis_pkg::eis_xfer_type xfer, xfer_w;
  logic [6:0] seen;
  int n_fail, tests_run, cycles;
  assign sda_line = m_sda & (oe_n | sda_out) & (oe_n_w | sda_out_w);
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  eis_bus_master i_master (.clk(clk), .sda_line(sda_line), .scl(scl),
    .sda(m_sda));
  eis_select_front_end i_dut (.clk(clk), .rstn(rstn), .scl_clk(scl),
    .scl_in(scl), .sda_in(sda_line), .sda_out(sda_out), .sda_oe_n(oe_n),
    .write_protect_input(wp), .chip_select_pin_high(cs_hi),
    .chip_select_pin_mid(cs_mid), .chip_select_pin_low(cs_lo),
    .por_reset_n(por_n), .selected(selected), .select_hit(hit),
    .select_miss(miss), .xfer(xfer), .data_valid(dv), .data_refused(dref),
    .write_stop(wstop), .read_nack(rnack), .frame_abort(fab));
  // Wide variant: all three select bits carry upper address
  eis_select_front_end #(.MEM_KBIT(16), .TYPE_ID(4'h5)) i_wide (.clk(clk),
    .rstn(rstn), .scl_clk(scl), .scl_in(scl), .sda_in(sda_line),
    .sda_out(sda_out_w), .sda_oe_n(oe_n_w), .write_protect_input(wp),
    .chip_select_pin_high(cs_hi), .chip_select_pin_mid(cs_mid),
    .chip_select_pin_low(cs_lo), .por_reset_n(por_n), .selected(sel_w),
    .select_hit(), .select_miss(), .xfer(xfer_w), .data_valid(),
    .data_refused(), .write_stop(), .read_nack(), .frame_abort());
  always @(posedge clk) begin
    seen <= seen | {fab, rnack, wstop, dref, dv, miss, hit};
    cycles <= cycles + 1;
    if (cycles == 40000) begin
      n_fail++;
      finish_test();
    end
  end
  task automatic chk_val(input logic [18:0] got, input logic [18:0] exp);
    tests_run++;
    if (got !== exp) begin
      n_fail++;
      $display("[ERR] %0t value %h expected %h", $time, got, exp);
    end
  endtask : chk_val
  task automatic chk_ack(input logic got, input logic exp);
    tests_run++;
    if (got !== exp) begin
      n_fail++;
      $display("[ERR] %0t ack %b expected %b", $time, got, exp);
    end
  endtask : chk_ack
  task automatic send(input logic [7:0] b, input logic mack,
                      input logic exp);
    logic a;
    i_master.xfer(b, mack, a);
    chk_ack(a, exp);
  endtask : send
  task automatic begin_frame(input logic [2:0] pins, input logic prot);
    {cs_hi, cs_mid, cs_lo} = pins;
    wp = prot;
    seen = '0;
    i_master.start();
  endtask : begin_frame
  task automatic t_write_ok();
    begin_frame(3'h5, 1'b0);
    send({4'h6, 3'h5, 1'b0}, 1'b0, 1'b1);
    send(8'h3C, 1'b0, 1'b1);
    send(8'hA5, 1'b0, 1'b1);
    chk_val(19'(xfer), {1'b0, 3'h0, 8'h3C, 8'hA5});
    i_master.stop();
    chk_val(19'(seen), 19'h15);
    chk_ack(selected, 1'b0);
  endtask : t_write_ok
  task automatic t_protect();
    begin_frame(3'h5, 1'b1);
    send({4'h6, 3'h5, 1'b0}, 1'b0, 1'b1);
    send(8'h11, 1'b0, 1'b1);
    send(8'h22, 1'b0, 1'b0);
    i_master.stop();
    chk_val(19'(seen), 19'h09);
  endtask : t_protect
  task automatic t_miss();
    logic [7:0] bad [4] = '{8'h7A, 8'h62, 8'h6E, 8'h68};
    for (int i = 0; i < 4; i++) begin
      begin_frame(3'h5, 1'b0);
      send(bad[i], 1'b0, 1'b0);
      i_master.stop();
      chk_val(19'(seen), 19'h02);
    end
    begin_frame(3'h2, 1'b0);
    send({4'h6, 3'h2, 1'b0}, 1'b0, 1'b1);
    i_master.stop();
    chk_val(19'(seen), 19'h01);
  endtask : t_miss
  task automatic t_read();
    begin_frame(3'h5, 1'b0);
    send({4'h6, 3'h5, 1'b1}, 1'b0, 1'b1);
    chk_ack(xfer.read_dir, 1'b1);
    send(8'hFF, 1'b0, 1'b0);
    i_master.stop();
    chk_val(19'(seen), 19'h21);
  endtask : t_read
  task automatic t_wide();
    begin_frame(3'h5, 1'b0);
    send({4'h5, 3'h6, 1'b0}, 1'b0, 1'b1);
    chk_val(19'(xfer_w.upper), 19'h6);
    chk_ack(sel_w, 1'b1);
    i_master.stop();
    chk_val(19'(seen), 19'h02);
  endtask : t_wide
  task automatic t_lockout();
    por_n = 1'b0;
    begin_frame(3'h5, 1'b0);
    send({4'h6, 3'h5, 1'b0}, 1'b0, 1'b0);
    i_master.stop();
    chk_val(19'(seen), 19'h00);
    por_n = 1'b1;
    i_master.gap(8);
  endtask : t_lockout
  task automatic t_abort();
    logic v;
    begin_frame(3'h5, 1'b0);
    for (int i = 0; i < 3; i++) begin
      i_master.pulse(1'b1, v);
    end
    i_master.stop();
    chk_val(19'(seen), 19'h40);
  endtask : t_abort
  task automatic finish_test();
    $display("comparisons %0d mismatches %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : finish_test
  initial begin
    {rstn, wp, cs_hi, cs_mid, cs_lo} = '0;
    por_n = 1'b1;
    seen = '0;
    n_fail = 0;
    tests_run = 0;
    cycles = 0;
    i_master.gap(20);
    rstn = 1'b1;
    i_master.gap(6);
    t_write_ok();
    t_protect();
    t_miss();
    t_read();
    t_wide();
    t_lockout();
    t_abort();
    t_write_ok();
    finish_test();
  end
endmodule : eis_select_front_end_tb_top
`default_nettype wire
